// ---- include/link_regs_pkg.sv ----
package link_regs_pkg;

  // ------------------------------------------------------------------
  // Register word indices (16-bit registers each take their own word)
  // ------------------------------------------------------------------
  // The printed offsets are not all multiples of four, so each one is an index.
  // The byte address on the bus is four times the index.
  localparam logic [7:0] DEV_CTRL_IDX = 8'h48;
  localparam logic [7:0] DEV_STAT_IDX = 8'h4A;
  localparam logic [7:0] LINK_CAP_IDX = 8'h4C;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h80;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h81;

  // ------------------------------------------------------------------
  // Device control fields
  // ------------------------------------------------------------------
  localparam int REPORT_EN_LSB = 0;
  localparam int PAYLOAD_LSB = 5;
  localparam int WIDE_TAG_BIT = 8;
  localparam int EXTRA_FN_BIT = 9;
  localparam int AUX_PM_BIT = 10;
  localparam int SNOOP_SKIP_BIT = 11;
  localparam int READ_REQ_LSB = 12;
  localparam logic [2:0] PAYLOAD_RESET = 3'h0;
  localparam logic [2:0] READ_REQ_RESET = 3'h2;
  localparam logic [3:0] REPORT_EN_RESET = 4'h0;
  localparam logic [2:0] PAYLOAD_MAX_CODE = 3'h4;

  // ------------------------------------------------------------------
  // Status flag positions
  // ------------------------------------------------------------------
  localparam int CORR_BIT = 0;
  localparam int NONFATAL_BIT = 1;
  localparam int FATAL_BIT = 2;
  localparam int UNSUP_BIT = 3;
  localparam int NUM_FLAGS = 4;

  // ------------------------------------------------------------------
  // Link capability constants
  // ------------------------------------------------------------------
  localparam logic [3:0] TOP_LINK_SPEED = 4'h1;
  localparam logic [5:0] TOP_LINK_WIDTH = 6'h08;
  localparam logic [1:0] POWER_STATE_SUPPORT = 2'h1;
  localparam logic [2:0] L0S_EXIT_DELAY = 3'h0;
  localparam logic [2:0] L1_EXIT_DELAY = 3'h0;
  localparam logic [7:0] PORT_INDEX = 8'h00;

  typedef struct packed {
    logic correctable;
    logic nonfatal;
    logic fatal;
    logic unsupported;
  } error_event_type;

  typedef struct packed {
    logic [2:0] read_request_limit;
    logic snoop_skip_enable;
    logic wide_tag_enable;
    logic [2:0] payload_limit;
    logic [3:0] report_enable;
  } control_type;

endpackage

// ---- logic/ntb_link_regs.sv ----
// Local design decision: the Wishbone slave port.
module ntb_link_regs
  import link_regs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Error events from the bridge core
  input wire error_event_type err_event,
  // Transaction attribute path
  input wire logic [7:0] pass_tag_in,
  input wire logic pass_snoop_in,
  input wire logic [2:0] pass_size_in,
  output logic [7:0] pass_tag_out,
  output logic pass_snoop_out,
  output logic [2:0] pass_size_out,
  output logic [7:0] own_tag,
  output logic own_snoop,
  output logic [12:0] payload_bytes,
  output logic [3:0] report_enable,
  output logic [3:0] error_report,
  output logic irq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    control_type ctrl;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] irq_flags;
    logic [NUM_FLAGS-1:0] irq_mask;
    logic [31:0] rdata;
    logic ack;
    logic err;
    logic irq;
    logic [7:0] tag_out;
    logic snoop_out;
    logic [2:0] size_out;
    logic [12:0] payload_bytes;
    logic [3:0] err_report;
  } state_type;

  state_type state;
  state_type next_state;

  logic [NUM_FLAGS-1:0] events;
  logic [7:0] index;
  logic take;
  logic wr;
  logic rd;
  logic [15:0] ctrl_word;
  logic [15:0] stat_word;
  logic [31:0] link_word;
  logic [15:0] wdata16;
  logic [1:0] lane_sel;

  assign events = {err_event.unsupported, err_event.fatal,
                   err_event.nonfatal, err_event.correctable};
  assign index = wb_adr_i[9:2];
  assign take = wb_cyc_i && wb_stb_i && !state.ack && !state.err;
  assign wr = take && wb_we_i;
  assign rd = take && !wb_we_i;
  assign wdata16 = wb_dat_i[15:0];
  assign lane_sel = wb_sel_i[1:0];

  // ------------------------------------------------------------------
  // Read views
  // ------------------------------------------------------------------
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[REPORT_EN_LSB +: 4] = state.ctrl.report_enable;
    ctrl_word[PAYLOAD_LSB +: 3] = state.ctrl.payload_limit;
    ctrl_word[WIDE_TAG_BIT] = state.ctrl.wide_tag_enable;
    ctrl_word[EXTRA_FN_BIT] = 1'b0;
    ctrl_word[AUX_PM_BIT] = 1'b0;
    ctrl_word[SNOOP_SKIP_BIT] = state.ctrl.snoop_skip_enable;
    ctrl_word[READ_REQ_LSB +: 3] = state.ctrl.read_request_limit;
    // Bits 4 (aux supply seen) and 5 (requests outstanding) stay zero
    stat_word = {12'h000, state.flags};
    link_word = {PORT_INDEX, 6'h00, L1_EXIT_DELAY, L0S_EXIT_DELAY,
                 POWER_STATE_SUPPORT, TOP_LINK_WIDTH, TOP_LINK_SPEED};
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.ack = 1'b0;
    next_state.err = 1'b0;
    next_state.rdata = 32'h0000_0000;
    if (take) begin
      unique case (index)
        DEV_CTRL_IDX, DEV_STAT_IDX, LINK_CAP_IDX, IRQ_STAT_IDX, IRQ_MASK_IDX: begin
          next_state.ack = 1'b1;
        end
        default: begin
          next_state.err = 1'b1;
        end
      endcase
    end
    // Control writes: only writable fields move; read-only bits ignore data
    if (wr && index == DEV_CTRL_IDX) begin
      if (lane_sel[0]) begin
        next_state.ctrl.report_enable = wdata16[REPORT_EN_LSB +: 4];
        next_state.ctrl.payload_limit = wdata16[PAYLOAD_LSB +: 3];
      end
      if (lane_sel[1]) begin
        next_state.ctrl.wide_tag_enable = wdata16[WIDE_TAG_BIT];
        next_state.ctrl.snoop_skip_enable = wdata16[SNOOP_SKIP_BIT];
        next_state.ctrl.read_request_limit = wdata16[READ_REQ_LSB +: 3];
      end
    end
    // Write one clears; a new event in the same cycle wins
    if (wr && index == DEV_STAT_IDX && lane_sel[0]) begin
      next_state.flags = state.flags & ~wdata16[NUM_FLAGS-1:0];
    end
    if (wr && index == IRQ_MASK_IDX && lane_sel[0]) begin
      next_state.irq_mask = wdata16[NUM_FLAGS-1:0];
    end
    if (rd && index == IRQ_STAT_IDX) begin
      next_state.irq_flags = '0;
    end
    // Flags log regardless of reporting enables
    next_state.flags = next_state.flags | events;
    next_state.irq_flags = next_state.irq_flags | events;
    if (rd) begin
      unique case (index)
        DEV_CTRL_IDX: next_state.rdata = {16'h0000, ctrl_word};
        DEV_STAT_IDX: next_state.rdata = {16'h0000, stat_word};
        LINK_CAP_IDX: next_state.rdata = link_word;
        IRQ_STAT_IDX: next_state.rdata = {28'h0000000, state.irq_flags};
        IRQ_MASK_IDX: next_state.rdata = {28'h0000000, state.irq_mask};
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end
    next_state.irq = |(next_state.irq_flags & next_state.irq_mask);
    next_state.err_report = events & state.ctrl.report_enable;
    // Pass-through attributes are forwarded untouched
    next_state.tag_out = pass_tag_in;
    next_state.snoop_out = pass_snoop_in;
    next_state.size_out = pass_size_in;
    // Reserved payload codes act as the smallest size
    if (state.ctrl.payload_limit > PAYLOAD_MAX_CODE) begin
      next_state.payload_bytes = 13'h0080;
    end else begin
      next_state.payload_bytes = 13'(13'h0080 << state.ctrl.payload_limit);
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= '0;
      state.ctrl.payload_limit <= PAYLOAD_RESET;
      state.ctrl.read_request_limit <= READ_REQ_RESET;
      state.ctrl.report_enable <= REPORT_EN_RESET;
      state.payload_bytes <= 13'h0080;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      own_tag <= 8'h00;
      own_snoop <= 1'b0;
      pass_size_out <= 3'h0;
    end else begin
      own_tag <= 8'h00;
      own_snoop <= 1'b0;
      pass_size_out <= next_state.size_out;
    end
  end

  assign wb_dat_o = state.rdata;
  assign wb_ack_o = state.ack;
  assign wb_err_o = state.err;
  assign irq = state.irq;
  assign pass_tag_out = state.tag_out;
  assign pass_snoop_out = state.snoop_out;
  assign payload_bytes = state.payload_bytes;
  assign report_enable = state.ctrl.report_enable;
  assign error_report = state.err_report;

endmodule

// ---- sim/link_regs_checker.sv ----
module link_regs_checker
  import link_regs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire error_event_type err_event,
  input wire logic [7:0] pass_tag_in,
  input wire logic [7:0] pass_tag_out,
  input wire logic pass_snoop_in,
  input wire logic pass_snoop_out,
  input wire logic [2:0] pass_size_in,
  input wire logic [2:0] pass_size_out,
  input wire logic [7:0] own_tag,
  input wire logic own_snoop,
  input wire logic [12:0] payload_bytes,
  input wire logic [3:0] report_enable,
  input wire logic [3:0] error_report
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_tag_pass: assert property (!$past(srst) |-> pass_tag_out == $past(pass_tag_in))
    else $error("pass tag altered");
  a_snoop_pass: assert property (!$past(srst) |-> pass_snoop_out == $past(pass_snoop_in))
    else $error("pass snoop altered");
  a_size_pass: assert property (!$past(srst) |-> pass_size_out == $past(pass_size_in))
    else $error("pass size altered");
  a_own_zero: assert property (own_tag == 8'h00 && !own_snoop)
    else $error("own attributes not zero");
  a_ack_next: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o)
    |=> (wb_ack_o ^ wb_err_o)) else $error("no single answer");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
  a_payload_set: assert property ($onehot(payload_bytes) && payload_bytes >= 13'h0080
    && payload_bytes <= 13'h0800) else $error("payload out of set");
  a_report_gate: assert property (!$past(srst) |->
    error_report == ($past(err_event) & $past(report_enable))) else $error("bad report");
  a_err_cause: assert property (wb_err_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("err without request");
  c_unmapped: cover property (wb_err_o);
  c_report: cover property (|error_report);
  c_payload_top: cover property (payload_bytes == 13'h0800);
endmodule

bind ntb_link_regs link_regs_checker i_chk (.*);

// ---- sim/event_source.sv ----
module event_source
  import link_regs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire error_event_type fire,
  output error_event_type err_event,
  output logic [7:0] tag,
  output logic snoop,
  output logic [2:0] size
);
  timeunit 1ns;
  timeprecision 1ns;
  // Attributes change every cycle so a stuck copy is seen
  always_ff @(posedge clk) begin
    err_event <= srst ? 4'h0 : fire;
    tag <= srst ? 8'hA5 : tag + 8'h01;
    snoop <= srst ? 1'b0 : !snoop;
    size <= srst ? 3'h0 : size + 3'h1;
  end
endmodule

// ---- sim/testbench.sv ----
module testbench;
  import link_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, e, ack, err, irq, snp;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic [7:0] tag;
  logic [2:0] sz;
  logic [12:0] pay;
  logic [3:0] ren;
  logic [3:0] sel = 4'hF;
  error_event_type fire = 4'h0, ev;
  int n_fail = 0, comparisons = 0;
  always #5 clk = ~clk;
  event_source i_src (.clk(clk), .srst(srst), .fire(fire), .err_event(ev), .tag(tag),
    .snoop(snp), .size(sz));
  ntb_link_regs i_dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .err_event(ev), .pass_tag_in(tag), .pass_snoop_in(snp),
    .pass_size_in(sz), .pass_tag_out(), .pass_snoop_out(), .pass_size_out(), .own_tag(),
    .own_snoop(), .payload_bytes(pay), .report_enable(ren), .error_report(), .irq(irq));
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (!(ack || err) && n < 20);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (!(ack || err)) begin
      n_fail++;
      finish_test();
    end
    @(posedge clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0);
    chk(name, exp, q);
  endtask
  task automatic pulse(input logic [3:0] v);
    fire <= v;
    @(posedge clk);
    fire <= 4'h0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(10'h120, 32'h0000_2000, "control reset");
    rd(10'h128, 32'h0, "status reset");
    rd(10'h130, 32'h0000_0481, "link cap");
    bus(1'b1, 10'h130, 32'hFFFF_FFFF);
    rd(10'h130, 32'h0000_0481, "link cap write");
    bus(1'b1, 10'h120, 32'h0000_FFFF);
    rd(10'h120, 32'h0000_79EF, "control write");
    chk("report enable", 32'hF, {28'h0, ren});
    sel <= 4'h1;
    bus(1'b1, 10'h120, 32'h0000_0000);
    sel <= 4'hF;
    rd(10'h120, 32'h0000_7900, "control low lane");
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 10'h120, {24'h0, 3'(c), 5'h00});
      chk("payload", (c < 5) ? (32'h80 << c) : 32'h80, {19'h0, pay});
    end
    $display("test payload done");
    for (int i = 0; i < 4; i++) begin
      pulse(4'h8 >> i);
      rd(10'h128, 32'h1 << i, "flag set");
      bus(1'b1, 10'h128, 32'h0);
      rd(10'h128, 32'h1 << i, "flag zero write");
      bus(1'b1, 10'h128, 32'h1 << i);
      rd(10'h128, 32'h0, "flag cleared");
    end
    $display("test status done");
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(10'h200, 32'hF, "irq status");
    rd(10'h200, 32'h0, "irq status read clear");
    bus(1'b1, 10'h204, 32'h4);
    rd(10'h204, 32'h4, "irq mask");
    pulse(4'h8);
    chk("irq other bit", 32'h0, {31'h0, irq});
    pulse(4'h2);
    chk("irq raised", 32'h1, {31'h0, irq});
    rd(10'h200, 32'h5, "irq status pair");
    chk("irq dropped", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    bus(1'b1, 10'h120, 32'h0000_000F);
    pulse(4'hF);
    bus(1'b0, 10'h3FC, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    $display("test report and unmapped done");
    finish_test();
  end
endmodule
